// ### hrp_sync.sv
// Behaviour
// - status resets to zero, chain bits live
// - reserved bits ignored on write, read zero
// - read/write registers keep last written value
// - double-buffered register reads last programmed value
// - written value reads back within five clocks
// - acknowledged status visible within eight clocks
// - active-low chip select, treated as asynchronous
// - drive data while read strobe low
// - write strobe tristates; capture at rising edge
// - respond only to selected address window
// - forward daisy-chain requests to interrupt output
// - interrupt output clocked once reset released
// - general inputs sampled and readable
// - output port register drives output pins
// - low reset input resets whole block
// - mask zero enables, one masks interrupt
// - any status write copies shadow, clears it
// - during reset interrupt follows chain inputs only
`timescale 1ns/1ps
`default_nettype none

package hrp_pkg;
   localparam int ADDR_W = 10;
   localparam int DATA_W = 32;
   localparam int IDX_W = 8;
   localparam int GPI_W = 20;
   localparam int GPO_W = 12;
   localparam int EVT_W = 16;
   // register indices inside the selected window
   localparam logic [7:0] IDX_CHAN_MODE = 8'h0F;
   localparam logic [7:0] IDX_INT_MASK = 8'h10;
   localparam logic [7:0] IDX_INT_STATUS = 8'h11;
   localparam logic [7:0] IDX_GPI = 8'h12;
   localparam logic [7:0] IDX_GPO = 8'h13;
   localparam logic [7:0] IDX_EPOCH_PARAM = 8'h14;
   // field layout
   localparam int INT_LSB = 9;
   localparam int INT_MSB = 24;
   localparam int CHAIN0_BIT = 0;
   localparam int CHAIN1_BIT = 1;
   localparam logic [31:0] MASK_RESET = 32'h01FF_FE00;
   localparam logic [31:0] MASK_USED = 32'h01FF_FE03;
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
   localparam logic [7:0] CHAN_ENABLE_MASK = 8'hFF;
   // register initialisation time after reset
   localparam int INIT_CYCLES = 32;
   localparam int SYNC_DEPTH = 3;
endpackage

// three-flop synchroniser; a bit counts once stages two and three agree
module hrp_sync #(
   parameter int W = 1
) (
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic [W-1:0] D,
   output logic [W-1:0] Q
);
   import hrp_pkg::*;

   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;
   logic [W-1:0] held;
   logic [W-1:0] next_held;

   // ---------------------------------------------------------------
   // agreement filter
   // ---------------------------------------------------------------
   // a disagreeing bit keeps its last agreed value
   always_comb
   begin
      next_held = (s2 ~^ s3) & s3 | ~(s2 ~^ s3) & held;
      Q = next_held;
   end

   // stage one feeds only stage two
   always_ff @(posedge CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
         held <= '0;
      end
      else
      begin
         s1 <= D;
         s2 <= s1;
         s3 <= s2;
         held <= next_held;
      end
   end

   // a zero-width synchroniser has nothing to carry
   if (W < 1)
   begin : g_bad_width
      $error("hrp_sync width must be positive");
   end
endmodule

`default_nettype wire

// ### hrp_port.sv
`timescale 1ns/1ps
`default_nettype none

module hrp_port (
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic CS_N,
   input wire logic RD_N,
   input wire logic WR_N,
   input wire logic [hrp_pkg::ADDR_W-1:0] ADDRESS,
   input wire logic [hrp_pkg::DATA_W-1:0] DATA_IN,
   output logic [hrp_pkg::DATA_W-1:0] DATA_OUT,
   output logic [hrp_pkg::DATA_W-1:0] DATA_OE,
   input wire logic WINDOW_SELECT_HI,
   input wire logic WINDOW_SELECT_LO,
   input wire logic CHAIN_IRQ_IN_0,
   input wire logic CHAIN_IRQ_IN_1,
   output logic IRQ_REQUEST_OUT,
   input wire logic [hrp_pkg::EVT_W-1:0] EVENT_IN,
   input wire logic EPOCH_IN,
   output logic [hrp_pkg::DATA_W-1:0] EPOCH_PARAM_EFFECTIVE,
   output logic [7:0] CHANNEL_MODE,
   input wire logic [hrp_pkg::GPI_W-1:0] GENERAL_INPUT_PORT,
   output logic [hrp_pkg::GPO_W-1:0] GENERAL_OUTPUT_PORT,
   output logic READY
);
   import hrp_pkg::*;

   localparam int SYNC_W = 3 + ADDR_W + DATA_W + 4 + GPI_W;

   // ---------------------------------------------------------------
   // elaboration checks
   // ---------------------------------------------------------------
   // the init counter is six bits, so the init span must fit below 64
   if (INIT_CYCLES < 1 || INIT_CYCLES > 63)
   begin : g_bad_init
      $error("init span does not fit its counter");
   end

   // the window compare needs two address bits above the register index
   if (ADDR_W < IDX_W + 2)
   begin : g_bad_addr
      $error("address too narrow for window and index");
   end

   logic [SYNC_W-1:0] sync_q;
   logic cs_s, rd_s, wr_s, win_hi_s, win_lo_s, chain0_s, chain1_s;
   logic [ADDR_W-1:0] addr_s;
   logic [DATA_W-1:0] data_s;
   logic [GPI_W-1:0] gpi_s;

   // ---------------------------------------------------------------
   // pin synchronisation
   // ---------------------------------------------------------------
   // every pin but EVENT_IN and EPOCH_IN crosses through the same depth so address and data
   // stay aligned with the strobes they belong to
   hrp_sync #(.W(SYNC_W)) u_sync (
      .CLK(CLK),
      .RSTN(RSTN),
      .D({CS_N, RD_N, WR_N, ADDRESS, DATA_IN, WINDOW_SELECT_HI, WINDOW_SELECT_LO,
          CHAIN_IRQ_IN_1, CHAIN_IRQ_IN_0, GENERAL_INPUT_PORT}),
      .Q(sync_q)
   );

   assign {cs_s, rd_s, wr_s, addr_s, data_s, win_hi_s, win_lo_s, chain1_s, chain0_s,
           gpi_s} = sync_q;

   // true when the upper address bits match the window straps
   function automatic logic in_window(input logic [ADDR_W-1:0] a, input logic hi,
                                      input logic lo);
      in_window = (a[ADDR_W-1:ADDR_W-2] == {hi, lo});
   endfunction

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   logic [5:0] init_cnt, next_init_cnt;
   logic wr_prev, next_wr_prev;
   logic cs_held, next_cs_held;
   logic [ADDR_W-1:0] waddr, next_waddr;
   logic [DATA_W-1:0] wdata, next_wdata;
   logic [DATA_W-1:0] mask, next_mask;
   logic [EVT_W-1:0] status, next_status;
   logic [EVT_W-1:0] shadow, next_shadow;
   logic [GPO_W-1:0] gpo, next_gpo;
   logic [GPI_W-1:0] gpi_q, next_gpi_q;
   logic [DATA_W-1:0] staged, next_staged;
   logic [DATA_W-1:0] effective, next_effective;
   logic [7:0] chan, next_chan;
   logic [DATA_W-1:0] rd_data, next_rd_data;
   logic irq_q, next_irq_q;
   logic wr_commit, busy, ack;
   logic [DATA_W-1:0] status_word;
   logic [IDX_W-1:0] widx, ridx;

   // write commit on the synchronised rising edge of the strobe
   always_comb
   begin
      busy = (init_cnt != 6'(INIT_CYCLES));
      next_init_cnt = busy ? init_cnt + 6'd1 : init_cnt;
      next_wr_prev = wr_s;
      next_waddr = waddr;
      next_wdata = wdata;
      next_cs_held = cs_held;
      // snapshot address and data while the strobe is low
      if (!wr_s)
      begin
         next_waddr = addr_s;
         next_wdata = data_s;
         next_cs_held = !cs_s;
      end
      // the synchroniser resets low, so a false strobe edge follows reset;
      // the init window swallows it, as it lasts far longer than the sync
      // writes during initialisation are dropped
      wr_commit = wr_s && !wr_prev && cs_held && !busy &&
                  in_window(waddr, win_hi_s, win_lo_s);
      widx = waddr[IDX_W-1:0];
      ack = wr_commit && (widx == IDX_INT_STATUS);
   end

   // register file; unused bits of a write are discarded
   always_comb
   begin
      next_mask = mask;
      next_gpo = gpo;
      next_staged = staged;
      next_chan = chan;
      // the read-only input register is never written
      if (wr_commit)
      begin
         if (widx == IDX_INT_MASK)
            next_mask = wdata & MASK_USED;
         else if (widx == IDX_GPO)
            next_gpo = wdata[GPO_W-1:0];
         else if (widx == IDX_EPOCH_PARAM)
            next_staged = wdata;
         else if (widx == IDX_CHAN_MODE)
            next_chan = wdata[7:0] & CHAN_ENABLE_MASK;
      end
      // staged value becomes effective only at the epoch
      next_effective = EPOCH_IN ? staged : effective;
      next_gpi_q = gpi_s;
   end

   // interrupt shadow and status; a new event beats the ack clear
   always_comb
   begin
      next_shadow = (ack ? '0 : shadow) | EVENT_IN;
      next_status = ack ? shadow : status;
      status_word = ZERO_WORD;
      status_word[INT_MSB:INT_LSB] = status;
      status_word[CHAIN0_BIT] = chain0_s;
      status_word[CHAIN1_BIT] = chain1_s;
      next_irq_q = |(status_word & ~mask);
   end

   // read mux, refreshed every cycle from the synchronised address
   always_comb
   begin
      ridx = addr_s[IDX_W-1:0];
      next_rd_data = ZERO_WORD;
      if (ridx == IDX_INT_MASK)
         next_rd_data = mask;
      else if (ridx == IDX_INT_STATUS)
         next_rd_data = status_word;
      else if (ridx == IDX_GPI)
         next_rd_data[GPI_W-1:0] = gpi_q;
      else if (ridx == IDX_GPO)
         next_rd_data[GPO_W-1:0] = gpo;
      else if (ridx == IDX_EPOCH_PARAM)
         next_rd_data = staged;
      else if (ridx == IDX_CHAN_MODE)
         next_rd_data[7:0] = chan;
   end

   // one register stage for the whole block
   always_ff @(posedge CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         init_cnt <= '0;
         wr_prev <= 1'b1;
         cs_held <= 1'b0;
         waddr <= '0;
         wdata <= '0;
         mask <= MASK_RESET;
         status <= '0;
         shadow <= '0;
         gpo <= '0;
         gpi_q <= '0;
         staged <= '0;
         effective <= '0;
         chan <= '0;
         rd_data <= '0;
         irq_q <= 1'b0;
      end
      else
      begin
         init_cnt <= next_init_cnt;
         wr_prev <= next_wr_prev;
         cs_held <= next_cs_held;
         waddr <= next_waddr;
         wdata <= next_wdata;
         mask <= next_mask;
         status <= next_status;
         shadow <= next_shadow;
         gpo <= next_gpo;
         gpi_q <= next_gpi_q;
         staged <= next_staged;
         effective <= next_effective;
         chan <= next_chan;
         rd_data <= next_rd_data;
         irq_q <= next_irq_q;
      end
   end

   // ---------------------------------------------------------------
   // pin outputs
   // ---------------------------------------------------------------
   // enable follows the raw strobes; the data itself is a flop, so a
   // host must allow the synchroniser delay before sampling
   always_comb
   begin
      DATA_OE = {DATA_W{RSTN && !CS_N && !RD_N && WR_N &&
                 in_window(ADDRESS, win_hi_s, win_lo_s)}};
      DATA_OUT = rd_data;
      // reset: pure gate of the chain pins; after: clocked
      IRQ_REQUEST_OUT = RSTN ? irq_q : (CHAIN_IRQ_IN_0 | CHAIN_IRQ_IN_1);
      GENERAL_OUTPUT_PORT = gpo;
      EPOCH_PARAM_EFFECTIVE = effective;
      CHANNEL_MODE = chan;
      READY = !busy;
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RSTN);

   sequence s_ack;
      ack ##0 (shadow != '0);
   endsequence

   init_clear_a: assert property (busy |-> status == '0)
      else $error("status not clear during init");
   init_block_a: assert property (busy |-> !wr_commit)
      else $error("write committed during init");
   write_tristate_a: assert property (!WR_N |-> DATA_OE == '0)
      else $error("data driven during write");
   out_port_a: assert property (wr_commit && widx == IDX_GPO |=>
      GENERAL_OUTPUT_PORT == $past(wdata[GPO_W-1:0]))
      else $error("output port missed write");
   readback_a: assert property (wr_commit && widx == IDX_GPO && ridx == IDX_GPO
      ##1 ridx == IDX_GPO |=> rd_data[GPO_W-1:0] == $past(wdata[GPO_W-1:0], 2))
      else $error("readback late");
   ack_copy_a: assert property (s_ack |=> status == $past(shadow))
      else $error("ack did not copy shadow");
   irq_mask_a: assert property (|(status_word & ~mask) |=> IRQ_REQUEST_OUT)
      else $error("unmasked interrupt not raised");
   window_hit_a: assert property (wr_commit |-> in_window(waddr, win_hi_s, win_lo_s))
      else $error("write outside window");
   buffer_epoch_a: assert property (EPOCH_IN |=>
      EPOCH_PARAM_EFFECTIVE == $past(staged))
      else $error("buffer not transferred at epoch");

   // ---------------------------------------------------------------
   // register write and status hold checks
   // ---------------------------------------------------------------
   // one committed write per target register; each property looks one
   // edge past the commit, where the register has loaded
   sequence s_mask_wr;
      wr_commit ##0 (widx == IDX_INT_MASK);
   endsequence

   sequence s_chan_wr;
      wr_commit ##0 (widx == IDX_CHAN_MODE);
   endsequence

   sequence s_stage_wr;
      wr_commit ##0 (widx == IDX_EPOCH_PARAM);
   endsequence

   mask_write_a: assert property (s_mask_wr |=> mask == ($past(wdata) & MASK_USED))
      else $error("mask write lost or reserved bits kept");
   chan_write_a: assert property (s_chan_wr |=> CHANNEL_MODE == $past(wdata[7:0]))
      else $error("channel mode write lost");
   stage_write_a: assert property (s_stage_wr |=> staged == $past(wdata))
      else $error("staged value write lost");
   // only an acknowledge may move the status word; events wait in the shadow
   status_hold_a: assert property (!ack |=> status == $past(status))
      else $error("status moved without acknowledge");
   ack_clear_a: assert property (ack |=> shadow == $past(EVENT_IN))
      else $error("shadow not cleared by acknowledge");
   effect_hold_a: assert property (!EPOCH_IN |=>
      EPOCH_PARAM_EFFECTIVE == $past(EPOCH_PARAM_EFFECTIVE))
      else $error("effective value moved without epoch");
   irq_quiet_a: assert property (!(|(status_word & ~mask)) |=> !IRQ_REQUEST_OUT)
      else $error("interrupt raised with nothing pending");
   read_tristate_a: assert property (RD_N |-> DATA_OE == '0)
      else $error("data driven without read strobe");
   gpi_sample_a: assert property (1'b1 |=> gpi_q == $past(gpi_s))
      else $error("input port not sampled");
   ready_hold_a: assert property (!busy |=> !busy)
      else $error("ready dropped without reset");
endmodule

`default_nettype wire

// ### hrp_sync_unused_note.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ### hrp_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// microprocessor side of the register port
// ----------------------------------------
module hrp_host_model (
   input wire logic clk,
   input wire logic [31:0] dev_data,
   input wire logic [31:0] dev_oe,
   output logic cs_n,
   output logic rd_n,
   output logic wr_n,
   output logic [9:0] addr,
   output logic [31:0] wr_bus
);
   // idle bus: deselected, strobes high
   initial
   begin
      cs_n = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
      addr = 10'h000;
      wr_bus = 32'h0000_0000;
   end

   // step just past a rising edge, where every pin change happens
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // strobe held four clocks so the on-chip sync sees it; the address
   // stays through the snapshot and the tail spaces writes apart
   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      addr = a;
      wr_bus = d;
      cs_n = 1'b0;
      wr_n = 1'b0;
      tick(4);
      wr_n = 1'b1;
      tick(4);
      cs_n = 1'b1;
      wr_bus = ~d; // old word must not linger on the wire
      tick(1);
   endtask

   // read data sits behind the sync, so wait before taking it
   task automatic rd(input logic [9:0] a, output logic [31:0] q, output logic [31:0] oe);
      addr = a;
      cs_n = 1'b0;
      rd_n = 1'b0;
      tick(7);
      q = dev_data;
      oe = dev_oe;
      rd_n = 1'b1;
      cs_n = 1'b1;
      tick(1);
   endtask
endmodule

`default_nettype wire

// ### host_register_port_bench.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------
// register port bench
// ------------------------------
module host_register_port_bench;
   import hrp_pkg::*;
   int fail_count = 0;
   int check_count = 0;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [1:0] win = 2'b10;
   logic [1:0] chain = 2'b01;
   logic [15:0] evt = 16'h0000;
   logic epoch = 1'b0;
   logic [19:0] gpi = 20'hABCDE;
   logic cs_n, rd_n, wr_n, irq, ready;
   logic [9:0] addr;
   logic [31:0] hdata, dout, doe, bus, eff, q, oe;
   logic [7:0] chan;
   logic [11:0] gpo;

   // wire level from both drivers of the data bus
   assign bus = (doe & dout) | (~doe & hdata);

   hrp_port i_dut (.CLK(clk), .RSTN(rstn), .CS_N(cs_n), .RD_N(rd_n), .WR_N(wr_n),
      .ADDRESS(addr), .DATA_IN(bus), .DATA_OUT(dout), .DATA_OE(doe),
      .WINDOW_SELECT_HI(win[1]), .WINDOW_SELECT_LO(win[0]), .CHAIN_IRQ_IN_0(chain[0]),
      .CHAIN_IRQ_IN_1(chain[1]), .IRQ_REQUEST_OUT(irq), .EVENT_IN(evt), .EPOCH_IN(epoch),
      .EPOCH_PARAM_EFFECTIVE(eff), .CHANNEL_MODE(chan), .GENERAL_INPUT_PORT(gpi),
      .GENERAL_OUTPUT_PORT(gpo), .READY(ready));

   hrp_host_model i_host (.clk(clk), .dev_data(bus), .dev_oe(doe), .cs_n(cs_n),
      .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .wr_bus(hdata));

   // 250 MHz core clock
   initial
   begin
      forever #2 clk = ~clk;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // every good read must also drive all data lines
   task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
      i_host.rd({win, idx}, q, oe);
      chk(q, exp);
      chk(oe, 32'hFFFF_FFFF);
   endtask

   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      i_host.wr({win, idx}, d);
   endtask

   // bounded wait for the initialisation to finish
   task automatic wait_ready;
      int n;
      n = 0;
      while (ready !== 1'b1 && n < 60)
      begin
         tick(1);
         n++;
      end
      chk({31'h0, ready}, 32'h1);
   endtask

   // in reset the interrupt line is a plain OR of the chain inputs
   task automatic t_reset;
      tick(1);
      chk({31'h0, irq}, 32'h1);
      chain = 2'b00;
      tick(1);
      chk({31'h0, irq}, 32'h0);
      chk(doe, ZERO_WORD);
      chain = 2'b10;
      rstn = 1'b1;
      wait_ready();
      tick(2);
      rdchk(IDX_INT_STATUS, 32'h0000_0002);
      rdchk(IDX_INT_MASK, MASK_RESET);
      chk({31'h0, irq}, 32'h1);
   endtask

   // output and input ports, reserved bits, window and unmapped index
   task automatic t_ports;
      wr(IDX_GPO, 32'hFFFF_FA5A);
      chk({20'h0, gpo}, 32'h0000_0A5A);
      rdchk(IDX_GPO, 32'h0000_0A5A);
      rdchk(IDX_GPI, 32'h000A_BCDE);
      i_host.wr({~win, IDX_GPO}, 32'h0000_0123);
      chk({20'h0, gpo}, 32'h0000_0A5A);
      i_host.rd({~win, IDX_GPO}, q, oe);
      chk(oe, ZERO_WORD);
      wr(8'hFF, 32'h1234_5678);
      rdchk(8'hFF, ZERO_WORD);
   endtask

   // event lands in status only on acknowledge; second ack clears it
   task automatic t_irq;
      wr(IDX_INT_MASK, 32'h01FF_FC02);
      tick(2);
      chk({31'h0, irq}, 32'h0);
      evt = 16'h0001;
      tick(1);
      evt = 16'h0000;
      tick(2);
      chk({31'h0, irq}, 32'h0);
      wr(IDX_INT_STATUS, 32'h0000_0000);
      tick(3);
      rdchk(IDX_INT_STATUS, 32'h0000_0202);
      chk({31'h0, irq}, 32'h1);
      wr(IDX_INT_STATUS, 32'hFFFF_FFFF);
      tick(3);
      rdchk(IDX_INT_STATUS, 32'h0000_0002);
      chk({31'h0, irq}, 32'h0);
      wr(IDX_INT_MASK, MASK_RESET);
      tick(2);
      chk({31'h0, irq}, 32'h1);
      chain = 2'b00;
      tick(6);
      chk({31'h0, irq}, 32'h0);
   endtask

   // staged value reads back at once but takes effect only at the epoch
   task automatic t_buffer;
      wr(IDX_EPOCH_PARAM, 32'h1234_5678);
      rdchk(IDX_EPOCH_PARAM, 32'h1234_5678);
      chk(eff, ZERO_WORD);
      epoch = 1'b1;
      tick(1);
      epoch = 1'b0;
      tick(2);
      chk(eff, 32'h1234_5678);
      wr(IDX_EPOCH_PARAM, 32'h0BAD_F00D);
      rdchk(IDX_EPOCH_PARAM, 32'h0BAD_F00D);
      chk(eff, 32'h1234_5678);
      wr(IDX_CHAN_MODE, 32'h0000_00C3);
      chk({24'h0, chan}, 32'h0000_00C3);
      rdchk(IDX_CHAN_MODE, 32'h0000_00C3);
   endtask

   // reset in mid-run clears outputs at once, without a clock edge
   task automatic t_midreset;
      chain = 2'b01;
      rstn = 1'b0;
      #1;
      chk({20'h0, gpo}, ZERO_WORD);
      chk(eff, ZERO_WORD);
      chk({24'h0, chan}, ZERO_WORD);
      chk({31'h0, irq}, 32'h1);
      tick(2);
      rstn = 1'b1;
      wait_ready();
      rdchk(IDX_GPO, ZERO_WORD);
   endtask

   task automatic end_sim;
      $display("checks=%0d mismatches=%0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // main sequence
   initial
   begin
      t_reset();
      t_ports();
      t_irq();
      t_buffer();
      t_midreset();
      end_sim();
   end

   // watchdog: the tests need well under 2000 cycles
   initial
   begin
      #20000;
      fail_count++;
      end_sim();
   end
endmodule

`default_nettype wire
